/* src/cbm_mover.v */
`timescale 1ns/1ns
`include "cbm_map.vh"
// How it works
// - any address with bits 7, 5, 4 and 2 set selects, B4 hex among them; then flag reads are answered.
// - select is a four-input AND of address bits 7, 5, 4 and 2.
// - when not selected the flag bus stays undriven, reading FF.
// - the initialize command deselects the controller.
// - idle flag bit 7 high before a move, low during, high after.
// - idle flag drops on the very edge the move command is taken.
// - initialize, or device clear while selected, aborts the move and sets idle.
// - printer busy shows on flag bit 0; open cable reads high.
// - a move loads source current from source start, then advances it.
// - current pointers stop changing no later than idle rises.
// - interrupt request copies idle one cycle later: high after idle is high, low otherwise.

// limitation: a move copies move_len characters and stops; end
// markers, margins and wrap are not handled here
module cbm_mover (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // host i/o select and commands
  input wire io_sel_strobe,
  input wire [7:0] io_addr,
  input wire flag_byte_read,
  input wire device_clear_cmd,
  input wire init_cmd,
  input wire move_cmd,
  // flag byte onto the host data bus
  output reg [7:0] flag_data_out,
  output reg flag_data_oe,
  // interrupt request
  output reg irq,
  // printer cable status pin
  input wire printer_busy_pin,
  // pointer window access
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // memory read port (source)
  output reg mem_rd_req,
  output reg [15:0] mem_rd_addr,
  input wire mem_rd_ack,
  input wire [7:0] mem_rd_data,
  // memory write port (destination)
  output reg mem_wr_req,
  output reg [15:0] mem_wr_addr,
  output reg [7:0] mem_wr_data,
  input wire mem_wr_ack
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // two states do; the fifo absorbs the speed gap of the two ports
  localparam MV_IDLE = 1'b0;
  localparam MV_RUN = 1'b1;

  reg mv_state;
  reg selected;
  reg [15:0] src_start;
  reg [15:0] src_cur;
  reg [15:0] dst_start;
  reg [15:0] dst_cur;
  reg [7:0] move_len;
  reg [8:0] rd_left;
  reg [8:0] wr_left;
  wire printer_busy;
  wire sel_match;
  wire abort;
  wire busy;
  wire start;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [7:0] fifo_out_data;
  wire rd_done;
  wire wr_done;
  wire last_wr;
  wire [7:0] flag_byte;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  // resets high so an unplugged cable never reads stuck low
  cbm_sync #(
    .RST_VAL(1'b1)
  ) u_pbusy_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(printer_busy_pin),
    .sync_out(printer_busy)
  );

  // ---------------------------------------------------------------
  // select decode and commands
  // ---------------------------------------------------------------
  // only the high bits of the code are wired to the gate, so any
  // address holding all four of them selects too (FF selects all)
  assign sel_match = io_addr[7] & io_addr[5] & io_addr[4] & io_addr[2];
  // device clear reaches only a selected controller; init reaches all
  assign abort = init_cmd | (device_clear_cmd & selected);
  assign busy = (mv_state == MV_RUN);
  assign start = move_cmd & selected & ~abort;

  // selection latch
  // init wins over a select strobe in the same cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      selected <= 1'b0;
    end else if (init_cmd) begin
      selected <= 1'b0;
    end else if (io_sel_strobe) begin
      selected <= sel_match;
    end
  end

  // ---------------------------------------------------------------
  // flag byte read
  // ---------------------------------------------------------------
  assign flag_byte = {~busy, 6'h00, printer_busy};

  // answer one cycle after the read strobe, for one cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_data_out <= `CBM_OPEN_BUS;
      flag_data_oe <= 1'b0;
    end else if (flag_byte_read & selected) begin
      flag_data_out <= flag_byte;
      flag_data_oe <= 1'b1;
    end else begin
      flag_data_out <= `CBM_OPEN_BUS;
      flag_data_oe <= 1'b0;
    end
  end

  // interrupt follows the idle flag
  // one cycle behind the flag, since it is registered
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b1;
    end else begin
      irq <= ~busy;
    end
  end

  // ---------------------------------------------------------------
  // move sequencer
  // ---------------------------------------------------------------
  assign rd_done = mem_rd_req & mem_rd_ack;
  assign wr_done = mem_wr_req & mem_wr_ack;
  assign last_wr = wr_done & (wr_left == 9'h001);

  // idle drops on the command edge itself, so a read right after
  // the command already sees busy
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mv_state <= MV_IDLE;
    end else begin
      case (mv_state)
        MV_IDLE: begin
          if (start) begin
            mv_state <= MV_RUN;
          end
        end
        MV_RUN: begin
          if (abort) begin
            mv_state <= MV_IDLE;
          end else if (start) begin
            // a restart reloads the counters; keep running
            mv_state <= MV_RUN;
          end else if (last_wr || wr_left == 9'h000) begin
            mv_state <= MV_IDLE;
          end
        end
        default: begin
          mv_state <= MV_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // source fetch side
  // ---------------------------------------------------------------
  // one read outstanding; space is checked before asking, and the
  // fifo only drains meanwhile, so the answer always fits
  assign fifo_in_valid = rd_done & busy;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_req <= 1'b0;
      mem_rd_addr <= 16'h0000;
      rd_left <= 9'h000;
    end else if (abort) begin
      mem_rd_req <= 1'b0;
      rd_left <= 9'h000;
    end else if (start) begin
      // a restart drops any request still waiting; its late ack
      // finds the request low and is ignored
      mem_rd_req <= 1'b0;
      rd_left <= {1'b0, move_len};
    end else if (busy) begin
      if (rd_done) begin
        mem_rd_req <= 1'b0;
        rd_left <= rd_left - 9'h001;
      end else if (!mem_rd_req && rd_left != 9'h000 && fifo_in_ready) begin
        mem_rd_req <= 1'b1;
        mem_rd_addr <= src_cur;
      end
    end
  end

  // ---------------------------------------------------------------
  // character buffer
  // ---------------------------------------------------------------
  // flushed on start and abort so no stale byte leaks into a move
  cbm_fifo #(
    .WIDTH(8),
    .DEPTH(`CBM_FIFO_DEPTH),
    .AW(`CBM_FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(abort | start),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(mem_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------
  // destination store side
  // ---------------------------------------------------------------
  // a slow write port stalls the pop, which backs up into fetches
  assign fifo_out_ready = busy & ~abort & ~mem_wr_req & fifo_out_valid;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_req <= 1'b0;
      mem_wr_addr <= 16'h0000;
      mem_wr_data <= 8'h00;
      wr_left <= 9'h000;
    end else if (abort) begin
      mem_wr_req <= 1'b0;
      wr_left <= 9'h000;
    end else if (start) begin
      // same as the fetch side: a restart forgets the old request
      mem_wr_req <= 1'b0;
      wr_left <= {1'b0, move_len};
    end else if (busy) begin
      if (wr_done) begin
        mem_wr_req <= 1'b0;
        wr_left <= wr_left - 9'h001;
      end else if (fifo_out_ready) begin
        mem_wr_req <= 1'b1;
        mem_wr_addr <= dst_cur;
        mem_wr_data <= fifo_out_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // pointer window: start, current and length registers
  // ---------------------------------------------------------------
  // host writes to current pointers are ignored mid-move so the
  // move's own updates are never torn
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_start <= {`CBM_PTR_RST, `CBM_PTR_RST};
      dst_start <= {`CBM_PTR_RST, `CBM_PTR_RST};
      src_cur <= {`CBM_PTR_RST, `CBM_PTR_RST};
      dst_cur <= {`CBM_PTR_RST, `CBM_PTR_RST};
      move_len <= `CBM_LEN_RST;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `CBM_SRC_START_LO: src_start[7:0] <= reg_wdata;
          `CBM_SRC_START_HI: src_start[15:8] <= reg_wdata;
          `CBM_DST_START_LO: dst_start[7:0] <= reg_wdata;
          `CBM_DST_START_HI: dst_start[15:8] <= reg_wdata;
          `CBM_MOVE_LEN: move_len <= reg_wdata;
          default: begin
          end
        endcase
      end
      if (start) begin
        src_cur <= src_start;
        dst_cur <= dst_start;
      end else if (busy) begin
        // abort freezes the pointers on the same edge
        if (rd_done && !abort) begin
          src_cur <= src_cur + 16'h0001;
        end
        if (wr_done && !abort) begin
          dst_cur <= dst_cur + 16'h0001;
        end
      end else if (reg_wr) begin
        case (reg_addr)
          `CBM_SRC_CUR_LO: src_cur[7:0] <= reg_wdata;
          `CBM_SRC_CUR_HI: src_cur[15:8] <= reg_wdata;
          `CBM_DST_CUR_LO: dst_cur[7:0] <= reg_wdata;
          `CBM_DST_CUR_HI: dst_cur[15:8] <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // read answer one cycle after the strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `CBM_SRC_START_LO: reg_rdata <= src_start[7:0];
          `CBM_SRC_START_HI: reg_rdata <= src_start[15:8];
          `CBM_SRC_CUR_LO: reg_rdata <= src_cur[7:0];
          `CBM_SRC_CUR_HI: reg_rdata <= src_cur[15:8];
          `CBM_DST_START_LO: reg_rdata <= dst_start[7:0];
          `CBM_DST_START_HI: reg_rdata <= dst_start[15:8];
          `CBM_DST_CUR_LO: reg_rdata <= dst_cur[7:0];
          `CBM_DST_CUR_HI: reg_rdata <= dst_cur[15:8];
          `CBM_MOVE_LEN: reg_rdata <= move_len;
          default: reg_rdata <= `CBM_UNMAPPED_RD;
        endcase
      end
    end
  end

endmodule

/* src/cbm_map.vh */
`ifndef CBM_MAP_VH
`define CBM_MAP_VH

// ---------------------------------------------------------------
// select decode
// ---------------------------------------------------------------
`define CBM_SEL_CODE 8'hB4
`define CBM_OPEN_BUS 8'hFF

// ---------------------------------------------------------------
// flag byte layout
// ---------------------------------------------------------------
`define CBM_FLAG_IDLE_BIT 7
`define CBM_FLAG_PBUSY_BIT 0

// ---------------------------------------------------------------
// pointer window offsets (12-bit memory window)
// ---------------------------------------------------------------
`define CBM_SRC_START_LO 12'h820
`define CBM_SRC_START_HI 12'h821
`define CBM_SRC_CUR_LO 12'h822
`define CBM_SRC_CUR_HI 12'h823
`define CBM_DST_START_LO 12'h860
`define CBM_DST_START_HI 12'h861
`define CBM_DST_CUR_LO 12'h862
`define CBM_DST_CUR_HI 12'h863
`define CBM_MOVE_LEN 12'h830

// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define CBM_PTR_RST 8'h00
`define CBM_LEN_RST 8'h00
`define CBM_UNMAPPED_RD 8'h00
`define CBM_FIFO_DEPTH 4
`define CBM_FIFO_AW 2

`endif

/* src/cbm_sync.v */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// two-flop level synchroniser
// ---------------------------------------------------------------
module cbm_sync #(
  parameter RST_VAL = 1'b1
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // level in and out
  input wire async_in,
  output reg sync_out
);

  reg stage1;

  // first stage feeds only the second
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* src/cbm_fifo.v */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// small character fifo, valid/ready on both sides
// ---------------------------------------------------------------
module cbm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // flush drops all entries
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage needs no reset; pointers do
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointer and occupancy bookkeeping
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* dv/cbm_mover_sva.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// port checker for the move controller
// ---------------------------------------------------------------
module cbm_mover_sva (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // host side
  input wire io_sel_strobe,
  input wire [7:0] io_addr,
  input wire flag_byte_read,
  input wire init_cmd,
  input wire move_cmd,
  // answers
  input wire [7:0] flag_data_out,
  input wire flag_data_oe,
  input wire irq,
  input wire mem_rd_req,
  input wire mem_wr_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // the four address bits that the select gate looks at
  wire hit = io_addr[7] & io_addr[5] & io_addr[4] & io_addr[2];
  // select cycles, a quiet cycle, and a plain flag read
  sequence good_sel; io_sel_strobe && hit && !init_cmd; endsequence
  sequence bad_sel; io_sel_strobe && !hit; endsequence
  sequence quiet; !io_sel_strobe && !init_cmd; endsequence
  sequence rd_only; flag_byte_read && !io_sel_strobe && !init_cmd;
  endsequence
  // the host reads two cycles after its select or initialize
  sequence good_rd; good_sel ##1 quiet ##1 rd_only; endsequence
  sequence bad_rd; bad_sel ##1 quiet ##1 rd_only; endsequence
  sequence init_rd; init_cmd ##1 quiet ##1 rd_only; endsequence
  a_sel_answers: assert property (good_rd |=> flag_data_oe)
    else $error("select code did not answer flag read");
  a_oe_cause: assert property (flag_data_oe |-> $past(flag_byte_read))
    else $error("flag driven without a read");
  a_bad_silent: assert property (bad_rd |=> !flag_data_oe)
    else $error("wrong address answered flag read");
  a_open_bus: assert property (!flag_data_oe |-> flag_data_out == 8'hFF)
    else $error("undriven flag bus not FF");
  a_init_desel: assert property (init_rd |=> !flag_data_oe)
    else $error("initialize left controller selected");
  a_idle_irq: assert property (flag_data_oe
    |-> flag_data_out[7] == irq)
    else $error("irq disagrees with idle flag");
  a_pad_bits: assert property (flag_data_oe
    |-> flag_data_out[6:1] == 6'h00)
    else $error("unused flag bits not zero");
  // initialize must drop both memory requests at once
  a_abort_drop: assert property ((init_cmd && !move_cmd)
    |=> !mem_rd_req && !mem_wr_req)
    else $error("memory request survived initialize");
endmodule

/* dv/cbm_mem_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// memory behind the mover, one ack per request
// ---------------------------------------------------------------
module cbm_mem_model (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // answer delay in cycles
  input logic [3:0] dly,
  // source reads
  input logic rd_req,
  input logic [15:0] rd_addr,
  output logic rd_ack,
  output logic [7:0] rd_data,
  // destination writes
  input logic wr_req,
  input logic [15:0] wr_addr,
  input logic [7:0] wr_data,
  output logic wr_ack,
  // record of writes
  output logic [7:0] last_wd,
  output logic [15:0] last_wa,
  output logic [7:0] wr_cnt
);
  logic [3:0] rc, wc;
  logic rdone, wdone;
  // data outside the ack is inverted so a stale sample shows up
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {rc, wc, rdone, wdone, rd_ack, wr_ack} <= '0;
      {rd_data, last_wd, last_wa, wr_cnt} <= '0;
    end else begin
      rd_ack <= 1'b0;
      wr_ack <= 1'b0;
      rd_data <= ~(rd_addr[7:0] ^ 8'h3C);
      rc <= rd_req ? rc + 4'h1 : 4'h0;
      wc <= wr_req ? wc + 4'h1 : 4'h0;
      if (!rd_req) rdone <= 1'b0;
      if (!wr_req) wdone <= 1'b0;
      if (rd_req && !rdone && rc >= dly) begin
        rd_ack <= 1'b1;
        rdone <= 1'b1;
        rd_data <= rd_addr[7:0] ^ 8'h3C;
      end
      if (wr_req && !wdone && wc >= dly) begin
        wr_ack <= 1'b1;
        wdone <= 1'b1;
        last_wd <= wr_data;
        last_wa <= wr_addr;
        wr_cnt <= wr_cnt + 8'h01;
      end
    end
  end
endmodule

/* dv/character_block_mover_control_test.sv */
`timescale 1ns/1ns
`include "cbm_map.vh"
module character_block_mover_control_test;
  logic ref_clk = 0, rst_n = 0, io_sel_strobe = 0, flag_byte_read = 0;
  logic device_clear_cmd = 0, init_cmd = 0, move_cmd = 0;
  logic printer_busy_pin = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] io_addr = 8'h00, reg_wdata = 8'h00, v, wc0;
  logic [11:0] reg_addr = 12'h000;
  logic [3:0] mem_dly = 4'h2;
  logic [15:0] p1, p2;
  logic [16:0] rows [0:8];
  wire [7:0] flag_data_out, reg_rdata, mem_rd_data, mem_wr_data;
  wire [7:0] last_wd, wr_cnt;
  wire [15:0] mem_rd_addr, mem_wr_addr, last_wa;
  wire flag_data_oe, irq, reg_rvalid, mem_rd_req, mem_rd_ack;
  wire mem_wr_req, mem_wr_ack;
  integer err_total = 0, n_tests = 0, i, k;

  // free running clock
  always #5 ref_clk = ~ref_clk;

  cbm_mover uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .io_sel_strobe(io_sel_strobe), .io_addr(io_addr),
    .flag_byte_read(flag_byte_read), .device_clear_cmd(device_clear_cmd),
    .init_cmd(init_cmd), .move_cmd(move_cmd),
    .flag_data_out(flag_data_out), .flag_data_oe(flag_data_oe),
    .irq(irq), .printer_busy_pin(printer_busy_pin),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
    .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack));

  cbm_mem_model mem (.ref_clk(ref_clk), .rst_n(rst_n), .dly(mem_dly),
    .rd_req(mem_rd_req), .rd_addr(mem_rd_addr), .rd_ack(mem_rd_ack),
    .rd_data(mem_rd_data), .wr_req(mem_wr_req), .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data), .wr_ack(mem_wr_ack), .last_wd(last_wd),
    .last_wa(last_wa), .wr_cnt(wr_cnt));

  // one compare for every result, all widened to 16 bits
  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // host command pulse: c = {select, device clear, init, move}
  task hostcmd(input [7:0] a, input [3:0] c);
    @(posedge ref_clk);
    io_addr <= a;
    {io_sel_strobe, device_clear_cmd, init_cmd, move_cmd} <= c;
    @(posedge ref_clk);
    {io_sel_strobe, device_clear_cmd, init_cmd, move_cmd} <= 4'h0;
  endtask

  // flag read; an undriven bus reads as all ones
  task rdflag(output [7:0] d);
    @(posedge ref_clk);
    flag_byte_read <= 1'b1;
    @(posedge ref_clk);
    flag_byte_read <= 1'b0;
    #1 d = flag_data_oe === 1'b1 ? flag_data_out : 8'hFF;
  endtask

  task regw(input [11:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task regr(input [11:0] a, output [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rvalid === 1'b1 ? reg_rdata : 8'hxx;
  endtask

  task rdptr(input [11:0] a, output [15:0] p);
    regr(a + 12'h001, p[15:8]);
    regr(a, p[7:0]);
  endtask

  // loads pointers and length, then selects and starts the move
  task start_move(input [7:0] len);
    regw(12'h822, 8'hEE);
    regw(12'h820, 8'h10);
    regw(12'h821, 8'h12);
    regw(12'h860, 8'h00);
    regw(12'h861, 8'h34);
    regw(12'h830, len);
    hostcmd(8'hB4, 4'h8);
    hostcmd(8'hB4, 4'h1);
  endtask

  // polls the idle flag a bounded number of times
  task wait_idle;
    v = 8'h00;
    for (i = 0; i < 300 && v[7] !== 1'b1; i = i + 1) rdflag(v);
    if (v[7] !== 1'b1) begin
      err_total = err_total + 1;
      end_sim;
    end
  endtask

  // main sequence
  initial begin
    // rows: address, printer pin, expected flag byte
    rows[0] = {8'hB4, 1'b1, 8'h81};
    rows[1] = {8'hB4, 1'b0, 8'h80};
    rows[2] = {8'hFF, 1'b1, 8'h81};
    rows[3] = {8'hF6, 1'b1, 8'h81};
    rows[4] = {8'hB0, 1'b1, 8'hFF};
    rows[5] = {8'hA4, 1'b1, 8'hFF};
    rows[6] = {8'h94, 1'b1, 8'hFF};
    rows[7] = {8'h34, 1'b1, 8'hFF};
    rows[8] = {8'h00, 1'b1, 8'hFF};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk({flag_data_oe, irq, mem_rd_req, mem_wr_req}, 16'h4);
    rdflag(v);
    chk(v, `CBM_OPEN_BUS);
    $display("test reset done");
    for (k = 0; k < 9; k = k + 1) begin
      @(posedge ref_clk) printer_busy_pin <= rows[k][8];
      hostcmd(rows[k][16:9], 4'h8);
      rdflag(v);
      chk(v, rows[k][7:0]);
    end
    regr(12'h7FF, v);
    chk(v, `CBM_UNMAPPED_RD);
    $display("test select table done");
    hostcmd(8'hB4, 4'h8);
    hostcmd(8'h00, 4'h2);
    rdflag(v);
    chk(v, `CBM_OPEN_BUS);
    hostcmd(8'hB4, 4'h8);
    rdflag(v);
    chk(v, 16'h81);
    $display("test initialize done");
    mem_dly <= 4'hF;
    wc0 = wr_cnt;
    start_move(8'h03);
    rdflag(v);
    chk(v, 16'h01);
    chk(irq, 1'b0);
    rdptr(12'h822, p1);
    chk(p1, 16'h1210);
    wait_idle;
    chk(irq, 1'b1);
    rdptr(12'h822, p1);
    chk(p1, 16'h1213);
    rdptr(12'h862, p2);
    chk(p2, 16'h3403);
    repeat (10) @(posedge ref_clk);
    rdptr(12'h822, p2);
    chk(p2, p1);
    chk(wr_cnt - wc0, 16'h3);
    chk({last_wa[7:0], last_wd}, 16'h022E);
    $display("test move done");
    start_move(8'h00);
    rdflag(v);
    chk(v, 16'h81);
    chk(irq, 1'b1);
    rdptr(12'h822, p1);
    chk(p1, 16'h1210);
    $display("test empty move done");
    mem_dly <= 4'h3;
    for (k = 0; k < 3; k = k + 1) begin
      start_move(8'hC8);
      rdflag(v);
      chk(v[7], 1'b0);
      if (k != 1) hostcmd(8'hB4, 4'h4);
      if (k != 0) begin
        hostcmd(8'h00, 4'h2);
        hostcmd(8'hB4, 4'h8);
      end
      rdflag(v);
      chk(v, 16'h81);
      rdptr(12'h822, p1);
      repeat (20) @(posedge ref_clk);
      rdptr(12'h822, p2);
      chk(p2, p1);
      $display("test abort %0d done", k);
    end
    end_sim;
  end
endmodule

bind cbm_mover cbm_mover_sva chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .io_sel_strobe(io_sel_strobe), .io_addr(io_addr),
  .flag_byte_read(flag_byte_read), .init_cmd(init_cmd),
  .move_cmd(move_cmd), .flag_data_out(flag_data_out),
  .flag_data_oe(flag_data_oe), .irq(irq), .mem_rd_req(mem_rd_req),
  .mem_wr_req(mem_wr_req));
